// ===== shared/colour_regs_pkg.sv
// constants and types for the colour offset and gain register bank
`default_nettype none
package colour_regs_pkg;
    localparam int NUM_COLOURS = 3;
    localparam int REG_W = 8;
    // word indices; byte address is four times the index
    localparam logic [5:0] TEST_CONTROL_IDX = 6'h00;
    localparam logic [5:0] SETUP_IDX = 6'h01;
    localparam logic [5:0] OFFSET_RED_IDX = 6'h02;
    localparam logic [5:0] OFFSET_BCAST_IDX = 6'h05;
    localparam logic [5:0] GAIN_RED_IDX = 6'h06;
    localparam logic [5:0] GAIN_BCAST_IDX = 6'h09;
    localparam logic [5:0] STATUS_IDX = 6'h0A;
    // field positions
    localparam int CLOCK_TEST_BIT = 7;
    localparam int COLOUR_SEL_LSB = 4;
    localparam int STATUS_GAIN_LSB = 8;
    // reset values
    localparam logic [7:0] TEST_CONTROL_RESET = 8'h00;
    localparam logic [7:0] OFFSET_RESET = 8'h80;
    localparam logic [7:0] GAIN_RESET = 8'h00;
    // gain in thousandths: base + code * span / divisor
    localparam logic [20:0] GAIN_BASE_MILLI = 21'h00_030C;
    localparam logic [20:0] GAIN_SPAN_MILLI = 21'h00_1D92;
    localparam logic [20:0] GAIN_DIVISOR = 21'h00_00FF;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef enum logic [1:0] {
        COLOUR_RED = 2'h0,
        COLOUR_GREEN = 2'h1,
        COLOUR_BLUE = 2'h2,
        COLOUR_RESERVED = 2'h3
    } colour_t;
endpackage
`default_nettype wire

// ===== hw/colour_path_select.sv
// picks the active colour's offset and gain and maps the gain code
`default_nettype none
module colour_path_select (
    // per-colour values
    input wire logic [7:0] offset_level [colour_regs_pkg::NUM_COLOURS],
    input wire logic [7:0] gain_code [colour_regs_pkg::NUM_COLOURS],
    // selection
    input wire colour_regs_pkg::colour_t colour_select,
    // chosen path settings
    output logic [7:0] sel_offset,
    output logic [7:0] sel_gain,
    output logic [13:0] sel_gain_milli
);
    import colour_regs_pkg::*;

    logic [1:0] idx;
    logic [20:0] product;

    // reserved code falls back to red so the path is always defined
    always_comb begin
        if (colour_select == COLOUR_RESERVED) begin
            idx = 2'h0;
        end else begin
            idx = colour_select;
        end
    end

    assign sel_offset = offset_level[idx];
    assign sel_gain = gain_code[idx];

    // same linear map for every colour
    assign product = {13'h0000, sel_gain} * GAIN_SPAN_MILLI;
    assign sel_gain_milli = 14'(GAIN_BASE_MILLI + product / GAIN_DIVISOR);
endmodule // colour_path_select
`default_nettype wire

// ===== hw/colour_offset_gain_regs.sv
// colour offset/gain register bank with clock-test output mux, AXI4-Lite slave
//
// Chosen here: the placing of the registers and the AXI4-Lite register port.
`default_nettype none
module colour_offset_gain_regs #(
    parameter int ADDR_W = 8
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // write address
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // read address
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // converter data and internal strobes, same clock
    input wire logic [3:0] adc_nibble,
    input wire logic internal_sample_pulse,
    input wire logic video_sample_clock,
    input wire logic converter_clock,
    input wire logic reset_sample_clock,
    // output pins and signal path settings
    output logic [3:0] output_nibble,
    output logic [7:0] applied_offset,
    output logic [7:0] applied_gain,
    output logic [13:0] applied_gain_milli
);
    import colour_regs_pkg::*;

    if (ADDR_W < 8) begin : g_addr_check
        $error("ADDR_W must be at least 8");
    end

    logic [7:0] test_control;
    colour_t colour_select;
    logic [7:0] offset_level [NUM_COLOURS];
    logic [7:0] gain_code [NUM_COLOURS];
    logic [5:0] wr_idx;
    logic [31:0] wr_data;
    logic wr_strb0;
    logic wr_fire;
    logic [5:0] rd_idx;
    logic [31:0] next_rdata;
    logic [1:0] next_rresp;
    logic [1:0] next_bresp;
    logic [7:0] sel_offset;
    logic [7:0] sel_gain;
    logic [13:0] sel_gain_milli;

    function automatic logic [5:0] colour_idx(input logic [5:0] base, input int c);
        colour_idx = base + 6'(c);
    endfunction

    function automatic logic is_mapped(input logic [5:0] idx);
        is_mapped = (idx <= STATUS_IDX);
    endfunction

    // ---------------- write channel ----------------
    // each channel is taken once and held until the response is accepted
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b1;
            wr_idx <= 6'h00;
        end else if (s_axi_awvalid && s_axi_awready) begin
            s_axi_awready <= 1'b0;
            wr_idx <= s_axi_awaddr[7:2];
        end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_awready <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_wready <= 1'b1;
            wr_data <= 32'h0000_0000;
            wr_strb0 <= 1'b0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            s_axi_wready <= 1'b0;
            wr_data <= s_axi_wdata;
            wr_strb0 <= s_axi_wstrb[0];
        end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_wready <= 1'b1;
        end
    end

    assign wr_fire = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;

    // broadcast and status locations are read-only or write-only, not errors
    always_comb begin
        if (is_mapped(wr_idx)) begin
            next_bresp = RESP_OKAY;
        end else begin
            next_bresp = RESP_SLVERR;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= next_bresp;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // ---------------- registers ----------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            test_control <= TEST_CONTROL_RESET;
        end else if (wr_fire && wr_strb0 && wr_idx == TEST_CONTROL_IDX) begin
            test_control <= wr_data[7:0];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            colour_select <= COLOUR_RED;
        end else if (wr_fire && wr_strb0 && wr_idx == SETUP_IDX) begin
            colour_select <= colour_t'(wr_data[COLOUR_SEL_LSB +: 2]);
        end
    end

    for (genvar c = 0; c < NUM_COLOURS; c++) begin : g_colour
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                offset_level[c] <= OFFSET_RESET;
            end else if (wr_fire && wr_strb0 && (wr_idx == OFFSET_BCAST_IDX
                    || wr_idx == colour_idx(OFFSET_RED_IDX, c))) begin
                offset_level[c] <= wr_data[7:0];
            end
        end

        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                gain_code[c] <= GAIN_RESET;
            end else if (wr_fire && wr_strb0 && (wr_idx == GAIN_BCAST_IDX
                    || wr_idx == colour_idx(GAIN_RED_IDX, c))) begin
                gain_code[c] <= wr_data[7:0];
            end
        end
    end

    // ---------------- read channel ----------------
    assign rd_idx = s_axi_araddr[7:2];

    // reads have no side effects; broadcast locations read as zero
    always_comb begin
        next_rdata = 32'h0000_0000;
        next_rresp = RESP_OKAY;
        if (rd_idx == TEST_CONTROL_IDX) begin
            next_rdata[7:0] = test_control;
        end else if (rd_idx == SETUP_IDX) begin
            next_rdata[COLOUR_SEL_LSB +: 2] = colour_select;
        end else if (rd_idx >= OFFSET_RED_IDX && rd_idx < OFFSET_BCAST_IDX) begin
            next_rdata[7:0] = offset_level[2'(rd_idx - OFFSET_RED_IDX)];
        end else if (rd_idx >= GAIN_RED_IDX && rd_idx < GAIN_BCAST_IDX) begin
            next_rdata[7:0] = gain_code[2'(rd_idx - GAIN_RED_IDX)];
        end else if (rd_idx == STATUS_IDX) begin
            next_rdata[7:0] = applied_offset;
            next_rdata[STATUS_GAIN_LSB +: 8] = applied_gain;
        end else if (rd_idx == OFFSET_BCAST_IDX || rd_idx == GAIN_BCAST_IDX) begin
            next_rdata = 32'h0000_0000;
        end else begin
            next_rresp = RESP_SLVERR;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= next_rdata;
            s_axi_rresp <= next_rresp;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
        end
    end

    // ---------------- signal path ----------------
    colour_path_select u_select (
        .offset_level(offset_level),
        .gain_code(gain_code),
        .colour_select(colour_select),
        .sel_offset(sel_offset),
        .sel_gain(sel_gain),
        .sel_gain_milli(sel_gain_milli)
    );

    // registered so the analogue settings never see a decode glitch
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            applied_offset <= OFFSET_RESET;
            applied_gain <= GAIN_RESET;
            applied_gain_milli <= 14'(GAIN_BASE_MILLI);
        end else begin
            applied_offset <= sel_offset;
            applied_gain <= sel_gain;
            applied_gain_milli <= sel_gain_milli;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            output_nibble <= 4'h0;
        end else if (test_control[CLOCK_TEST_BIT]) begin
            output_nibble <= {internal_sample_pulse, video_sample_clock,
                converter_clock, reset_sample_clock};
        end else begin
            output_nibble <= adc_nibble;
        end
    end

    // ---------------- checks ----------------
    nibble_normal_a: assert property (@(posedge aclk) disable iff (!aresetn)
        !test_control[CLOCK_TEST_BIT] |=> output_nibble == $past(adc_nibble))
        else $error("output nibble not carrying converter data");

    nibble_test_a: assert property (@(posedge aclk) disable iff (!aresetn)
        test_control[CLOCK_TEST_BIT] |=> output_nibble == {$past(internal_sample_pulse),
            $past(video_sample_clock), $past(converter_clock), $past(reset_sample_clock)})
        else $error("output nibble not carrying internal strobes");

    test_reset_a: assert property (@(posedge aclk)
        !aresetn ##1 aresetn |-> test_control == 8'h00
            ##1 output_nibble == $past(adc_nibble))
        else $error("test control not cleared by reset");

    offset_reset_a: assert property (@(posedge aclk)
        !aresetn |=> offset_level[0] == 8'h80 && offset_level[1] == 8'h80
            && offset_level[2] == 8'h80 && gain_code[0] == 8'h00)
        else $error("offset or gain reset value wrong");

    offset_follow_a: assert property (@(posedge aclk) disable iff (!aresetn)
        colour_select == COLOUR_GREEN |=> applied_offset == $past(offset_level[1]))
        else $error("applied offset not from selected colour");

    offset_broadcast_a: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_fire && wr_strb0 && wr_idx == OFFSET_BCAST_IDX |=>
            offset_level[0] == $past(wr_data[7:0]) && offset_level[1] == $past(wr_data[7:0])
            && offset_level[2] == $past(wr_data[7:0]))
        else $error("broadcast offset write missed a colour");

    gain_select_a: assert property (@(posedge aclk) disable iff (!aresetn)
        colour_select == COLOUR_BLUE ##1 colour_select == COLOUR_BLUE
            |=> applied_gain == $past(gain_code[2]))
        else $error("applied gain not from selected colour");

    gain_map_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (applied_gain == 8'hFF |-> applied_gain_milli == 14'h209E)
        and (applied_gain == 8'h00 |-> applied_gain_milli == 14'h030C))
        else $error("gain mapping endpoints wrong");

    colour_reset_a: assert property (@(posedge aclk)
        !aresetn |=> colour_select == COLOUR_RED)
        else $error("colour select not red after reset");

    gain_broadcast_a: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_fire && wr_strb0 && wr_idx == GAIN_BCAST_IDX |=>
            gain_code[0] == $past(wr_data[7:0]) && gain_code[2] == $past(wr_data[7:0])
            && gain_code[1] == $past(wr_data[7:0]))
        else $error("broadcast gain write missed a colour");

    bcast_read_a: assert property (@(posedge aclk) disable iff (!aresetn)
        s_axi_arvalid && s_axi_arready && !wr_fire
            && (rd_idx == OFFSET_BCAST_IDX || rd_idx == GAIN_BCAST_IDX)
            |=> s_axi_rvalid && s_axi_rdata == 32'h0000_0000 && $stable(offset_level[0])
            && $stable(gain_code[0]))
        else $error("broadcast read not zero or disturbed a register");

    reserved_red_a: assert property (@(posedge aclk) disable iff (!aresetn)
        colour_select == COLOUR_RESERVED |=> applied_offset == $past(offset_level[0])
            && applied_gain == $past(gain_code[0]))
        else $error("reserved colour did not apply red values");

    offset_red_a: assert property (@(posedge aclk) disable iff (!aresetn)
        colour_select == COLOUR_RED |=> applied_offset == $past(offset_level[0]))
        else $error("applied offset not from red");

    offset_blue_a: assert property (@(posedge aclk) disable iff (!aresetn)
        colour_select == COLOUR_BLUE |=> applied_offset == $past(offset_level[2]))
        else $error("applied offset not from blue");

    gain_red_a: assert property (@(posedge aclk) disable iff (!aresetn)
        colour_select == COLOUR_RED |=> applied_gain == $past(gain_code[0]))
        else $error("applied gain not from red");

    gain_green_a: assert property (@(posedge aclk) disable iff (!aresetn)
        colour_select == COLOUR_GREEN |=> applied_gain == $past(gain_code[1]))
        else $error("applied gain not from green");

    gain_reset_a: assert property (@(posedge aclk)
        !aresetn |=> gain_code[1] == 8'h00 && gain_code[2] == 8'h00
            && applied_gain == 8'h00)
        else $error("gain codes not cleared by reset");

    select_write_a: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_fire && wr_strb0 && wr_idx == SETUP_IDX
            |=> colour_select == $past(wr_data[COLOUR_SEL_LSB +: 2]))
        else $error("colour select not loaded from setup write");

    lane_guard_a: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_fire && !wr_strb0 |=> $stable(offset_level[0]) && $stable(gain_code[0])
            && $stable(test_control))
        else $error("write with low lane off changed a register");

    mode_switch_a: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_fire && wr_strb0 && wr_idx == TEST_CONTROL_IDX
            |=> test_control[CLOCK_TEST_BIT] == $past(wr_data[CLOCK_TEST_BIT]))
        else $error("clock test bit not taken from bit 7");

endmodule // colour_offset_gain_regs
`default_nettype wire

// ===== tb/tb.sv
// self-checking bench for the colour offset and gain register bank
`default_nettype none
`define CHK(a, b, m) begin comparisons++; if ((a) !== (b)) begin failures++; \
    $display("wrong value at %0t: %s", $time, m); end end
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import colour_regs_pkg::*;
    logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, isp, vsc, cc, rsc;
    logic [7:0] awaddr, araddr, off [3], gn [3], v, applied_offset, applied_gain;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb, adc_nibble, output_nibble, cap_adc, cap_str;
    logic [1:0] bresp, rresp;
    logic [13:0] applied_gain_milli;
    logic [1:0] bq [$];
    logic [33:0] rq [$];
    logic [31:0] rst_tab [11] = '{0, 0, 32'h80, 32'h80, 32'h80, 0, 0, 0, 0, 0, 32'h80};
    int seed = 32'hb18d;
    int failures = 0;
    int comparisons = 0;
    int k;

    colour_offset_gain_regs colour_offset_gain_regs_i (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .adc_nibble(adc_nibble),
        .internal_sample_pulse(isp), .video_sample_clock(vsc), .converter_clock(cc),
        .reset_sample_clock(rsc), .output_nibble(output_nibble),
        .applied_offset(applied_offset), .applied_gain(applied_gain),
        .applied_gain_milli(applied_gain_milli));

    initial begin
        aclk = 0;
        forever #5 aclk = ~aclk;
    end

    // converter data and strobes change every cycle; cap_* holds what the last edge saw
    always @(posedge aclk) begin
        cap_adc <= adc_nibble;
        cap_str <= {isp, vsc, cc, rsc};
        {adc_nibble, isp, vsc, cc, rsc} <= 8'($random(seed));
    end

    // results are compared in order of arrival against the oldest note
    always @(posedge aclk) begin
        if (bvalid && bready) `CHK(bresp, bq.pop_front(), "write response")
        if (rvalid && rready) `CHK({rresp, rdata}, rq.pop_front(), "read data")
    end

    task automatic complete_run();
        if (failures == 0 && comparisons > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    task automatic wr(input logic [5:0] i, input logic [7:0] d, input logic [3:0] st = 4'h1,
                      input logic [1:0] rs = RESP_OKAY);
        @(posedge aclk);
        awaddr <= {i, 2'b00};
        wdata <= {24'($random(seed)), d};
        wstrb <= st;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        bq.push_back(rs);
        do begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (!(bvalid && bready));
        bready <= 1'b0;
    endtask

    task automatic rd(input logic [5:0] i, input logic [31:0] d,
                      input logic [1:0] rs = RESP_OKAY);
        @(posedge aclk);
        araddr <= {i, 2'b00};
        arvalid <= 1'b1;
        rready <= 1'b1;
        rq.push_back({rs, d});
        do begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
        end while (!(rvalid && rready));
        rready <= 1'b0;
    endtask

    task automatic chk_path(input logic [7:0] o, input logic [7:0] g);
        logic [13:0] m;
        m = 14'(780 + int'(g) * 7570 / 255);
        repeat (2) @(posedge aclk);
        #1;
        `CHK(applied_offset, o, "applied offset")
        `CHK(applied_gain, g, "applied gain")
        `CHK(applied_gain_milli, m, "gain mapping")
    endtask

    // compares the output pins over several cycles against strobes or data
    task automatic chk_nibble(input logic test_on);
        repeat (2) @(posedge aclk);
        repeat (8) begin
            @(posedge aclk);
            #1;
            if (test_on) `CHK(output_nibble, cap_str, "strobe nibble")
            else `CHK(output_nibble, cap_adc, "data nibble")
        end
    endtask

    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
        {awaddr, araddr, wdata, wstrb} = '0;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        chk_path(OFFSET_RESET, GAIN_RESET);
        for (int i = 0; i < 11; i++) rd(6'(i), rst_tab[i]);
        chk_nibble(1'b0);
        // unmapped word just past the status register
        rd(6'h0B, 0, RESP_SLVERR);
        wr(6'h0B, 8'h5A, 4'h1, RESP_SLVERR);
        for (int c = 0; c < 3; c++) begin
            off[c] = 8'($random(seed));
            gn[c] = 8'($random(seed));
            wr(6'(OFFSET_RED_IDX + c), off[c]);
            wr(6'(GAIN_RED_IDX + c), gn[c]);
        end
        for (int c = 0; c < 4; c++) begin
            wr(SETUP_IDX, 8'(c << COLOUR_SEL_LSB));
            rd(SETUP_IDX, 32'(c << COLOUR_SEL_LSB));
            k = (c == 3) ? 0 : c;
            chk_path(off[k], gn[k]);
            rd(STATUS_IDX, {16'h0, gn[k], off[k]});
        end
        // a write with the low lane disabled leaves the register alone
        wr(OFFSET_RED_IDX, ~off[0], 4'h0);
        rd(OFFSET_RED_IDX, 32'(off[0]));
        v = 8'($random(seed));
        wr(OFFSET_BCAST_IDX, v);
        rd(OFFSET_BCAST_IDX, 0);
        for (int c = 0; c < 3; c++) rd(6'(OFFSET_RED_IDX + c), 32'(v));
        wr(GAIN_BCAST_IDX, 8'hFF);
        rd(GAIN_BCAST_IDX, 0);
        for (int c = 0; c < 3; c++) rd(6'(GAIN_RED_IDX + c), 32'h0000_00FF);
        chk_path(v, 8'hFF);
        wr(TEST_CONTROL_IDX, 8'h80);
        rd(TEST_CONTROL_IDX, 32'h0000_0080);
        chk_nibble(1'b1);
        // other test bits set, clock test off: data must return
        wr(TEST_CONTROL_IDX, 8'h7F);
        chk_nibble(1'b0);
        // reset in mid-run with the clock test on: all settings return to defaults
        wr(TEST_CONTROL_IDX, 8'h80);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        rd(TEST_CONTROL_IDX, 32'h0000_0000);
        rd(OFFSET_RED_IDX, 32'(OFFSET_RESET));
        rd(SETUP_IDX, 32'h0000_0000);
        chk_path(OFFSET_RESET, GAIN_RESET);
        chk_nibble(1'b0);
        complete_run();
    end

    // the sequence needs well under two thousand cycles
    initial begin
        repeat (20000) @(posedge aclk);
        failures++;
        complete_run();
    end
endmodule // tb
`default_nettype wire
